// ==== dv/msb_host_model.sv ====
// host board model driving the module sideband pins
`timescale 1ns/1ps
module msb_host_model #(
    parameter int SETUP_CYC = 4
) (
    input wire logic clock_i,  // core clock
    input wire logic sel_want_i,  // bench asks to select
    input wire logic drive_want_i,  // bench asks to drive select
    input wire logic cmd_want_i,  // bench asks for a command
    input wire logic cmd_force_i,  // command even when not allowed
    input wire logic absent_pin_i,  // absent pin level from module
    input wire logic absent_oe_i,  // absent pin drive enable
    output logic module_select_n_o,  // select pin
    output logic module_select_driven_o,  // host drives select
    output logic mgmt_cmd_valid_o,  // command on the serial bus
    output logic absent_seen_o  // absent line as host reads it
);
    logic sel_now;
    logic sel_prev_q = 1'b0;
    int unsigned settle_q = 0;
    // select as actually driven onto the pin
    assign sel_now = sel_want_i & drive_want_i;
    // cycles since the driven select last changed
    always @(posedge clock_i) begin
        sel_prev_q <= sel_now;
        settle_q <= (sel_prev_q != sel_now) ? 0 : settle_q + 1;
    end
    // pull-up lives in the module: a released line shows a stray level
    assign module_select_driven_o = drive_want_i;
    assign module_select_n_o = ~sel_want_i;
    // traffic only to a driven-selected module after the setup wait, unless cmd_force_i is set
    assign mgmt_cmd_valid_o = cmd_want_i & (cmd_force_i |
        (sel_now & (settle_q >= SETUP_CYC)));
    assign absent_seen_o = absent_oe_i ? absent_pin_i : 1'b1;
endmodule : msb_host_model

// ==== dv/tb_top.sv ====
// self-checking bench for the module sideband pin logic
`timescale 1ns/1ps
module tb_top;
    import msb_pkg::*;
    logic clock_i = 0, rst_i = 1, ce_i = 1, module_select_n_i, module_select_driven_i;
    logic low_power_request_i = 0, module_reset_n_i = 1, rx_power_low_i = 0, mgmt_cmd_valid_i;
    logic mgmt_cmd_accept_o, mgmt_enable_o, low_power_mode_o, high_power_enable_o, irq_o;
    logic receive_signal_lost_o, module_absent_flag_o, module_absent_flag_oe_o;
    logic transmit_monitor_clock_out_o, transmit_monitor_clock_out_oe_o, hresp_o, hreadyout_o;
    logic hsel_i = 0, hwrite_i = 0, hready_i, absent_seen;
    logic [1:0] htrans_i = 0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
    logic sel_w = 0, drv_w = 0, cmd_w = 0, frc_w = 0;
    int err_count = 0, cmp_count = 0, cyc = 0;
    assign hready_i = hreadyout_o;
    always #5 clock_i = ~clock_i;
    msb_sideband #(.LP_ENTER_CYC(34'd20), .HP_INIT_CYC(34'd10), .INIT_CYC(34'd30)) DUT (
        .clock_i, .rst_i, .ce_i, .module_select_n_i, .module_select_driven_i,
        .low_power_request_i, .module_reset_n_i, .rx_power_low_i, .mgmt_cmd_valid_i,
        .mgmt_cmd_accept_o, .mgmt_enable_o, .low_power_mode_o, .high_power_enable_o,
        .receive_signal_lost_o, .module_absent_flag_o, .module_absent_flag_oe_o,
        .transmit_monitor_clock_out_o, .transmit_monitor_clock_out_oe_o, .irq_o, .hsel_i,
        .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hreadyout_o,
        .hresp_o, .hrdata_o);
    msb_host_model HOST (.clock_i, .sel_want_i(sel_w), .drive_want_i(drv_w),
        .cmd_want_i(cmd_w), .cmd_force_i(frc_w), .absent_pin_i(module_absent_flag_o),
        .absent_oe_i(module_absent_flag_oe_o), .module_select_n_o(module_select_n_i),
        .module_select_driven_o(module_select_driven_i), .mgmt_cmd_valid_o(mgmt_cmd_valid_i),
        .absent_seen_o(absent_seen));
    task automatic test_done();
        $display("errors %0d of %0d compares", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one single-word transfer, waits on hready in both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock_i);
        hsel_i <= 1; htrans_i <= 2'b10; haddr_i <= {24'h0, a}; hwrite_i <= w;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 0; htrans_i <= 2'b00; hwdata_i <= wd;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask : ahb
    task automatic wait_hp(input logic v);
        for (int i = 0; i < 300 && high_power_enable_o !== v; i++) @(posedge clock_i);
    endtask : wait_hp
    // bounded run length
    always @(posedge clock_i) if (++cyc > 6000) begin err_count++; test_done(); end
    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 0;
        ahb(0, REG_CTRL, 0); check(rd, 32'(CTRL_RESET));
        ahb(0, REG_RESET_MIN, 0); check(rd, 32'(RESET_MIN_DEF));
        ahb(0, 8'h40, 0); check(rd, 32'h0);
        check({absent_seen, transmit_monitor_clock_out_oe_o}, 2'b00);
        check({transmit_monitor_clock_out_o, hresp_o}, 2'b00);
        cmd_w <= 1; frc_w <= 1; sel_w <= 1; repeat (4) @(posedge clock_i);
        check({mgmt_enable_o, mgmt_cmd_accept_o}, 2'b00);
        sel_w <= 1; drv_w <= 1; frc_w <= 0; ahb(1, REG_INT_STATUS, 32'h10);
        sel_w <= 0; cmd_w <= 0; frc_w <= 1; repeat (4) @(posedge clock_i);
        cmd_w <= 1; @(posedge clock_i); check(mgmt_cmd_accept_o, 0);
        ahb(0, REG_INT_STATUS, 0); check(rd[EV_CMD_IGNORED], 1);
        frc_w <= 0; sel_w <= 1; wait_hp(1); check(low_power_mode_o, 0);
        low_power_request_i <= 1; repeat (26) @(posedge clock_i);
        ahb(0, REG_STATUS, 0); check({rd[STS_LP_BIT], high_power_enable_o}, 2'b10);
        check({mgmt_enable_o, mgmt_cmd_accept_o}, 2'b11);
        low_power_request_i <= 0; repeat (10) @(posedge clock_i);
        check(high_power_enable_o, 0); wait_hp(1); check(high_power_enable_o, 1);
        ahb(0, REG_INT_STATUS, 0); check(rd[3:1], 3'h7);
        rx_power_low_i <= 1; repeat (45) @(posedge clock_i);
        check(receive_signal_lost_o, 0); repeat (15) @(posedge clock_i);
        check({receive_signal_lost_o, irq_o}, 2'b10);
        ahb(1, REG_INT_MASK, 32'h1); @(posedge clock_i); check(irq_o, 1);
        ahb(1, REG_INT_STATUS, 32'h1); repeat (2) @(posedge clock_i); check(irq_o, 0);
        ahb(1, REG_RESET_MIN, 32'h4); ahb(1, REG_CTRL, 32'h3);
        module_reset_n_i <= 0; repeat (3) @(posedge clock_i); module_reset_n_i <= 1;
        repeat (4) @(posedge clock_i); ahb(0, REG_CTRL, 0); check(rd, 32'h3);
        check({low_power_mode_o, high_power_enable_o}, 2'b10);
        module_reset_n_i <= 0; repeat (12) @(posedge clock_i); module_reset_n_i <= 1;
        repeat (4) @(posedge clock_i); ahb(0, REG_CTRL, 0); check(rd, 32'h2);
        ahb(0, REG_RESET_MIN, 0); check(rd, 32'(RESET_MIN_DEF));
        // clock enable low must freeze the init countdown
        check(low_power_mode_o, 1); ce_i <= 0; repeat (40) @(posedge clock_i);
        check(low_power_mode_o, 1); ce_i <= 1; wait_hp(1); check(high_power_enable_o, 1);
        test_done();
    end
endmodule : tb_top

// ==== shared/msb_pkg.sv ====
// constants and types shared by the module sideband pin logic
package msb_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint NS_PER_MS = 1000000;
    localparam longint NS_PER_S = 1000000000;
    localparam int CNT_W = 34;
    localparam longint T_LP_ENTER_MAX_MS = 9500;
    localparam longint T_HP_INIT_MIN_MS = 100;
    localparam longint T_HP_INIT_MAX_MS = 10000;
    localparam longint T_INIT_MIN_S = 19;
    localparam longint T_INIT_MAX_S = 120;
    localparam longint T_LOS_MIN_NS = 500;
    localparam longint T_LOS_MAX_NS = 400000;
    // longest times round down, least times round up
    localparam longint LP_ENTER_MAX_CYC = T_LP_ENTER_MAX_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam longint HP_INIT_MIN_CYC =
        (T_HP_INIT_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint HP_INIT_MAX_CYC = T_HP_INIT_MAX_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam longint INIT_MIN_CYC = (T_INIT_MIN_S * NS_PER_S + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam longint INIT_MAX_CYC = T_INIT_MAX_S * NS_PER_S / CLK_PERIOD_NS;
    localparam int LOS_CNT_W = 16;
    localparam logic [LOS_CNT_W-1:0] LOS_MIN_CYC =
        LOS_CNT_W'((T_LOS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [LOS_CNT_W-1:0] LOS_MAX_CYC = LOS_CNT_W'(T_LOS_MAX_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_INT_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_RESET_MIN = 8'h10;
    localparam int CTRL_FORCE_LP_BIT = 0;
    localparam int CTRL_LOS_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam int STS_SELECTED_BIT = 0;
    localparam int STS_LP_BIT = 1;
    localparam int STS_HP_BIT = 2;
    localparam int STS_INIT_BIT = 3;
    localparam int STS_LOS_BIT = 4;
    localparam int STS_TRANSIT_BIT = 5;
    localparam int EV_W = 5;
    localparam int EV_LOS_CHANGE = 0;
    localparam int EV_LP_ENTERED = 1;
    localparam int EV_HP_ENTERED = 2;
    localparam int EV_INIT_DONE = 3;
    localparam int EV_CMD_IGNORED = 4;
    localparam logic [EV_W-1:0] INT_MASK_RESET = 5'h00;
    localparam int RMIN_W = 16;
    localparam logic [RMIN_W-1:0] RESET_MIN_DEF = 16'h03e8;
    localparam int HTRANS_ACTIVE_BIT = 1;

    // ------------------------------------------------------------
    // input synchroniser lanes
    // ------------------------------------------------------------
    localparam int SYNC_W = 4;
    localparam int SY_SEL = 0;
    localparam int SY_LP = 1;
    localparam int SY_RST = 2;
    localparam int SY_RXLOW = 3;
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 4'hf;

    typedef enum logic [2:0] {
        PWR_INIT,
        PWR_LOW,
        PWR_TO_HIGH,
        PWR_HIGH,
        PWR_TO_LOW
    } msb_pwr_state_t;

endpackage : msb_pkg

// ==== src/msb_sideband.sv ====
// module sideband pin control: select gating, power modes, reset, loss of signal
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
module msb_sideband
    import msb_pkg::*;
#(
    parameter logic [CNT_W-1:0] LP_ENTER_CYC = CNT_W'(LP_ENTER_MAX_CYC),
    parameter logic [CNT_W-1:0] HP_INIT_CYC = CNT_W'(HP_INIT_MIN_CYC),
    parameter logic [CNT_W-1:0] INIT_CYC = CNT_W'(INIT_MIN_CYC)
) (
    input wire logic clock_i,  // core clock, 100 MHz
    input wire logic rst_i,  // async reset, high
    input wire logic ce_i,  // clock enable
    input wire logic module_select_n_i,  // select pin level, low selects
    input wire logic module_select_driven_i,  // host actively drives select
    input wire logic low_power_request_i,  // low-power request pin
    input wire logic module_reset_n_i,  // reset pin, low resets
    input wire logic rx_power_low_i,  // optical power below threshold
    input wire logic mgmt_cmd_valid_i,  // serial engine has a command
    output logic mgmt_cmd_accept_o,  // command may be answered
    output logic mgmt_enable_o,  // serial engine may respond
    output logic low_power_mode_o,  // power rails in low-power mode
    output logic high_power_enable_o,  // full power operation enabled
    output logic receive_signal_lost_o,  // loss of signal pin
    output logic module_absent_flag_o,  // absent pin output level
    output logic module_absent_flag_oe_o,  // absent pin drive enable
    output logic transmit_monitor_clock_out_o,  // monitor clock pin level
    output logic transmit_monitor_clock_out_oe_o,  // monitor clock drive enable
    output logic irq_o,  // level interrupt
    input wire logic hsel_i,  // ahb select
    input wire logic [31:0] haddr_i,  // ahb address
    input wire logic [1:0] htrans_i,  // ahb transfer type
    input wire logic hwrite_i,  // ahb write
    input wire logic [2:0] hsize_i,  // ahb size
    input wire logic [31:0] hwdata_i,  // ahb write data
    input wire logic hready_i,  // ahb bus ready
    output logic hreadyout_o,  // ahb slave ready
    output logic hresp_o,  // ahb response
    output logic [31:0] hrdata_o  // ahb read data
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (LP_ENTER_CYC < 1 || longint'(LP_ENTER_CYC) > LP_ENTER_MAX_CYC) begin : g_chk_lp
        $error("low-power entry count out of range");
    end
    if (HP_INIT_CYC < 1 || longint'(HP_INIT_CYC) > HP_INIT_MAX_CYC) begin : g_chk_hp
        $error("high-power init count out of range");
    end
    if (INIT_CYC < 1 || longint'(INIT_CYC) > INIT_MAX_CYC) begin : g_chk_init
        $error("reset init count out of range");
    end

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic sel_pin_n;
    logic [SYNC_W-1:0] sync_q;

    // an undriven select line floats high
    assign sel_pin_n = module_select_n_i | ~module_select_driven_i;

    msb_sync #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST_VAL)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i({rx_power_low_i, module_reset_n_i, low_power_request_i, sel_pin_n}),
        .q_o(sync_q)
    );

    logic selected;
    assign selected = ~sync_q[SY_SEL];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    msb_pwr_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [RMIN_W:0] rst_low_cnt_q, rst_low_cnt_d;
    logic [LOS_CNT_W-1:0] los_cnt_q, los_cnt_d;
    logic los_q, los_d;
    logic los_pin_q, los_pin_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic [EV_W-1:0] int_status_q, int_status_d;
    logic [EV_W-1:0] int_mask_q, int_mask_d;
    logic [RMIN_W-1:0] reset_min_q, reset_min_d;
    logic wr_pend_q, wr_pend_d;
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic soft_rst;
    logic lp_req;
    logic addr_ok;
    logic [EV_W-1:0] events;
    logic [31:0] rd_word;

    assign soft_rst = ~sync_q[SY_RST] && (rst_low_cnt_q == {1'b0, reset_min_q});
    assign lp_req = sync_q[SY_LP] | ctrl_q[CTRL_FORCE_LP_BIT];
    assign addr_ok = hsel_i && htrans_i[HTRANS_ACTIVE_BIT] && hready_i;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        rst_low_cnt_d = rst_low_cnt_q;
        los_cnt_d = los_cnt_q;
        los_d = los_q;
        ctrl_d = ctrl_q;
        int_mask_d = int_mask_q;
        reset_min_d = reset_min_q;
        wr_pend_d = 1'b0;
        wr_addr_d = wr_addr_q;
        hrdata_d = hrdata_q;
        events = '0;
        // reset pin low-time counter, saturating just past the minimum
        if (sync_q[SY_RST]) begin
            rst_low_cnt_d = '0;
        end else if (rst_low_cnt_q <= {1'b0, reset_min_q}) begin
            rst_low_cnt_d = rst_low_cnt_q + 1'b1;
        end
        // loss of signal qualifier, needs a stable run to flip
        if (sync_q[SY_RXLOW] == los_q) begin
            los_cnt_d = '0;
        end else if (los_cnt_q == LOS_MIN_CYC - 1'b1) begin
            los_d = sync_q[SY_RXLOW];
            los_cnt_d = '0;
            events[EV_LOS_CHANGE] = 1'b1;
        end else begin
            los_cnt_d = los_cnt_q + 1'b1;
        end
        // power mode sequencer
        unique case (state_q)
            PWR_INIT: begin
                if (!sync_q[SY_RST]) begin
                    cnt_d = '0;
                end else if (cnt_q == INIT_CYC - 1'b1) begin
                    cnt_d = '0;
                    events[EV_INIT_DONE] = 1'b1;
                    state_d = lp_req ? PWR_LOW : PWR_TO_HIGH;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            PWR_LOW: begin
                if (!lp_req) begin
                    state_d = PWR_TO_HIGH;
                end
            end
            PWR_TO_HIGH: begin
                if (lp_req) begin
                    cnt_d = '0;
                    state_d = PWR_TO_LOW;
                end else if (cnt_q == HP_INIT_CYC - 1'b1) begin
                    cnt_d = '0;
                    state_d = PWR_HIGH;
                    events[EV_HP_ENTERED] = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            PWR_HIGH: begin
                if (lp_req) begin
                    state_d = PWR_TO_LOW;
                end
            end
            PWR_TO_LOW: begin
                if (!lp_req) begin
                    cnt_d = '0;
                    state_d = PWR_TO_HIGH;
                end else if (cnt_q == LP_ENTER_CYC - 1'b1) begin
                    cnt_d = '0;
                    state_d = PWR_LOW;
                    events[EV_LP_ENTERED] = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
        endcase
        events[EV_CMD_IGNORED] = mgmt_cmd_valid_i & ~selected;
        // ahb address phase: capture writes, prefetch reads
        if (addr_ok && hwrite_i) begin
            wr_pend_d = 1'b1;
            wr_addr_d = haddr_i[ADDR_W-1:0];
        end
        if (addr_ok && !hwrite_i) begin
            hrdata_d = (haddr_i[31:ADDR_W] == '0) ? rd_word : 32'h0000_0000;
        end
        // ahb data phase: commit writes
        if (wr_pend_q) begin
            unique case (wr_addr_q)
                REG_CTRL: ctrl_d = hwdata_i[1:0];
                REG_INT_MASK: int_mask_d = hwdata_i[EV_W-1:0];
                REG_RESET_MIN: reset_min_d = hwdata_i[RMIN_W-1:0];
                default: ;
            endcase
        end
        // sticky events, write one to clear, a new event wins
        int_status_d = int_status_q;
        if (wr_pend_q && wr_addr_q == REG_INT_STATUS) begin
            int_status_d = int_status_q & ~hwdata_i[EV_W-1:0];
        end
        int_status_d = int_status_d | events;
        los_pin_d = los_d & ctrl_d[CTRL_LOS_EN_BIT];
        // complete reset restores every user setting
        if (soft_rst) begin
            state_d = PWR_INIT;
            cnt_d = '0;
            ctrl_d = CTRL_RESET;
            int_mask_d = INT_MASK_RESET;
            reset_min_d = RESET_MIN_DEF;
            int_status_d = '0;
            los_pin_d = los_d & CTRL_RESET[CTRL_LOS_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // registers, frozen while clock enable is low
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= PWR_INIT;
            cnt_q <= '0;
            rst_low_cnt_q <= '0;
            los_cnt_q <= '0;
            los_q <= 1'b1;
            los_pin_q <= 1'b1;
            ctrl_q <= CTRL_RESET;
            int_status_q <= '0;
            int_mask_q <= INT_MASK_RESET;
            reset_min_q <= RESET_MIN_DEF;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata_q <= '0;
        end else if (ce_i) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rst_low_cnt_q <= rst_low_cnt_d;
            los_cnt_q <= los_cnt_d;
            los_q <= los_d;
            los_pin_q <= los_pin_d;
            ctrl_q <= ctrl_d;
            int_status_q <= int_status_d;
            int_mask_q <= int_mask_d;
            reset_min_q <= reset_min_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (haddr_i[ADDR_W-1:0])
            REG_CTRL: rd_word[1:0] = ctrl_q;
            REG_STATUS: begin
                rd_word[STS_SELECTED_BIT] = selected;
                rd_word[STS_LP_BIT] = state_q == PWR_LOW;
                rd_word[STS_HP_BIT] = state_q == PWR_HIGH;
                rd_word[STS_INIT_BIT] = state_q == PWR_INIT;
                rd_word[STS_LOS_BIT] = los_q;
                rd_word[STS_TRANSIT_BIT] = state_q == PWR_TO_HIGH || state_q == PWR_TO_LOW;
            end
            REG_INT_STATUS: rd_word[EV_W-1:0] = int_status_q;
            REG_INT_MASK: rd_word[EV_W-1:0] = int_mask_q;
            REG_RESET_MIN: rd_word[RMIN_W-1:0] = reset_min_q;
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // commands pass only while selected, in any power mode
    assign mgmt_enable_o = selected;
    assign mgmt_cmd_accept_o = mgmt_cmd_valid_i & selected;
    assign low_power_mode_o = state_q != PWR_HIGH && state_q != PWR_TO_HIGH;
    assign high_power_enable_o = state_q == PWR_HIGH;
    assign receive_signal_lost_o = los_pin_q;
    // absent pin pulled to ground internally
    assign module_absent_flag_o = 1'b0;
    assign module_absent_flag_oe_o = 1'b1;
    // no monitor clock, and no reference clock port exists at all
    assign transmit_monitor_clock_out_o = 1'b0;
    assign transmit_monitor_clock_out_oe_o = 1'b0;
    assign irq_o = |(int_status_q & int_mask_q);
    assign hreadyout_o = ce_i;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_sel_seen(logic v);
        ce_i && sel_pin_n == v ##1 ce_i;
    endsequence

    a_select_answer: assert property (@(posedge clock_i) disable iff (rst_i)
        s_sel_seen(1'b0) ##1 mgmt_cmd_valid_i |-> mgmt_cmd_accept_o)
        else $error("selected module did not answer");
    a_deselect_ignore: assert property (@(posedge clock_i) disable iff (rst_i)
        s_sel_seen(1'b1) ##1 1'b1 |-> !mgmt_cmd_accept_o && !mgmt_enable_o)
        else $error("deselected module answered");
    a_pullup_deselect: assert property (@(posedge clock_i) disable iff (rst_i)
        ce_i && !module_select_driven_i ##1 ce_i ##1 1'b1 |-> !mgmt_enable_o)
        else $error("floating select left module selected");
    a_lowpower_answer: assert property (@(posedge clock_i) disable iff (rst_i)
        state_q == PWR_LOW && !sync_q[SY_SEL] && mgmt_cmd_valid_i |-> mgmt_cmd_accept_o)
        else $error("no answer in low power");
    a_lp_entry_bound: assert property (@(posedge clock_i) disable iff (rst_i)
        state_q == PWR_TO_LOW |-> cnt_q < LP_ENTER_CYC && low_power_mode_o)
        else $error("low-power entry overran");
    a_hp_init_time: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(state_q == PWR_HIGH) |-> $past(state_q) == PWR_TO_HIGH
            && $past(cnt_q) == HP_INIT_CYC - 1'b1)
        else $error("high power reached at wrong time");
    a_reset_filter: assert property (@(posedge clock_i) disable iff (rst_i)
        ce_i && soft_rst |=> state_q == PWR_INIT && cnt_q == '0 && $past(!sync_q[SY_RST], 1)
            && $past(rst_low_cnt_q) > {1'b0, RMIN_W'(0)} + {1'b0, $past(reset_min_q) - 1'b1})
        else $error("reset filter misfired");
    a_reset_defaults: assert property (@(posedge clock_i) disable iff (rst_i)
        ce_i && soft_rst |=> ctrl_q == CTRL_RESET && int_mask_q == INT_MASK_RESET
            && reset_min_q == RESET_MIN_DEF && int_status_q == '0)
        else $error("settings not restored by reset");
    a_init_bound: assert property (@(posedge clock_i) disable iff (rst_i)
        state_q == PWR_INIT && $past(state_q) == PWR_INIT && $past(ce_i)
            && $past(sync_q[SY_RST]) |-> cnt_q <= INIT_CYC - 1'b1)
        else $error("init overran");
    a_los_delay: assert property (@(posedge clock_i) disable iff (rst_i)
        $changed(los_q) |-> $past(ce_i) && $past(los_cnt_q) == LOS_MIN_CYC - 1'b1
            && los_q == $past(sync_q[SY_RXLOW]))
        else $error("loss of signal changed without qualification");
    a_absent_low: assert property (@(posedge clock_i) disable iff (rst_i)
        module_absent_flag_oe_o && !module_absent_flag_o)
        else $error("absent pin not held low");
    a_no_monitor_clk: assert property (@(posedge clock_i) disable iff (rst_i)
        !transmit_monitor_clock_out_oe_o)
        else $error("monitor clock driven");

endmodule : msb_sideband

// ==== src/msb_sync.sv ====
// two-flop synchroniser bank for the host sideband inputs
`timescale 1ns/1ps
module msb_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clock_i,  // core clock
    input wire logic rst_i,  // async reset, high
    input wire logic ce_i,  // clock enable
    input wire logic [W-1:0] d_i,  // raw inputs
    output logic [W-1:0] q_o  // synchronised outputs
);

    // ------------------------------------------------------------
    // one two-stage lane per bit
    // ------------------------------------------------------------
    for (genvar g = 0; g < W; g++) begin : g_lane
        logic meta_q;
        logic meta_d;
        logic sync_q;
        logic sync_d;

        // hold while clock enable is low
        always_comb begin
            meta_d = ce_i ? d_i[g] : meta_q;
            sync_d = ce_i ? meta_q : sync_q;
        end

        // first stage feeds only the second
        always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
                meta_q <= RST_VAL[g];
                sync_q <= RST_VAL[g];
            end else begin
                meta_q <= meta_d;
                sync_q <= sync_d;
            end
        end

        assign q_o[g] = sync_q;
    end

endmodule : msb_sync
